/* File: hdl/ppcs_pkg.sv */
// Package with register offsets, bit positions, reset values and mode codes.
package ppcs_pkg;
  localparam int NUM_PORTS = 5;
  localparam logic [7:0] OFS_PORT1 = 8'h1f;
  localparam logic [7:0] OFS_PORT2 = 8'h2f;
  localparam logic [7:0] OFS_PORT3 = 8'h3f;
  localparam logic [7:0] OFS_PORT4 = 8'h4f;
  localparam logic [7:0] OFS_PORT5 = 8'h5f;
  localparam logic [7:0] OFS_STATUS_DELTA = 8'h01;
  localparam int BIT_LOOPBACK = 7;
  localparam int BIT_RSVD = 6;
  localparam int BIT_ISOLATE = 5;
  localparam int BIT_SOFT_RST = 4;
  localparam int BIT_FORCE_LINK = 3;
  localparam int BIT_P10HD = 0;
  localparam logic [2:0] MODE_AN = 3'h1;
  localparam logic [2:0] MODE_10HD = 3'h2;
  localparam logic [2:0] MODE_100HD = 3'h3;
  localparam logic [2:0] MODE_10FD = 3'h5;
  localparam logic [2:0] MODE_100FD = 3'h6;
  localparam logic [2:0] MODE_RESET = MODE_AN;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int RST_PULSE_CYCLES = 16;

  function automatic logic mode_is_legal(input logic [2:0] m);
    return (m == MODE_AN) || (m == MODE_10HD) || (m == MODE_100HD) ||
           (m == MODE_10FD) || (m == MODE_100FD);
  endfunction
endpackage

/* File: hdl/ppcs_port_ctl.sv */
// One port's PHY control bits, soft reset sequencer and mode capture.
`timescale 1ns/1ps
module ppcs_port_ctl
  import ppcs_pkg::*;
#(
  parameter int RST_CYCLES = RST_PULSE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [2:0] op_mode_i,
  input wire logic partner_10hd_i,
  output logic [7:0] ctl_q_o,
  output logic p10hd_o,
  output logic phy_soft_rst_o
);
  typedef enum logic [0:0] {PPCS_IDLE, PPCS_RST} ppcs_state_t;
  ppcs_state_t state_q;
  logic [15:0] cnt_q;
  logic loop_q, iso_q, force_q;
  logic [2:0] mode_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loop_q <= 1'b0;
      iso_q <= 1'b0;
      force_q <= 1'b0;
    end else if (wr_i) begin
      loop_q <= wdata_i[BIT_LOOPBACK];
      iso_q <= wdata_i[BIT_ISOLATE];
      force_q <= wdata_i[BIT_FORCE_LINK];
    end
  end

  // A write of 1 during a running sequence restarts the count.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= PPCS_IDLE;
      cnt_q <= 16'h0000;
    end else begin
      case (state_q)
        PPCS_IDLE: begin
          if (wr_i && wdata_i[BIT_SOFT_RST]) begin
            state_q <= PPCS_RST;
            cnt_q <= 16'(RST_CYCLES - 1);
          end
        end
        PPCS_RST: begin
          if (wr_i && wdata_i[BIT_SOFT_RST]) begin
            cnt_q <= 16'(RST_CYCLES - 1);
          end else if (cnt_q == 16'h0000) begin
            state_q <= PPCS_IDLE;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        default: state_q <= PPCS_IDLE;
      endcase
    end
  end

  // Reserved input codes are ignored so the field never shows one.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= MODE_RESET;
      p10hd_o <= 1'b0;
    end else begin
      if (mode_is_legal(op_mode_i)) begin
        mode_q <= op_mode_i;
      end
      p10hd_o <= partner_10hd_i;
    end
  end

  assign phy_soft_rst_o = (state_q == PPCS_RST);
  // Reserved bit 6 is tied to zero on read.
  assign ctl_q_o = {loop_q, 1'b0, iso_q, phy_soft_rst_o, force_q, mode_q};
endmodule

/* File: hdl/ppcs_top.sv */
// Per-port PHY control and status register bank for a five-port switch.
`timescale 1ns/1ps
// What this block does
// - Status bit 0 reports partner 10BT half-duplex ability, zero after reset.
// - One register per port at 0x1f, 0x2f, 0x3f, 0x4f, 0x5f, same layout.
// - Bit 7 loops frames back at the port PHY PMD/PMA layer.
// - Bit 5 isolates the PHY from MII side and line transmit pair.
// - Writing 1 to bit 4 starts a self-clearing PHY soft reset.
// - Bit 3 forces the PHY link up regardless of line status.
// - Bits 2-0 report operation mode; reset value 001, auto-negotiation.
// - Control, but not status, is also readable through the MIIM port when miim_sel_i is high.
module ppcs_top
  import ppcs_pkg::*;
#(
  parameter int PORTS = NUM_PORTS,
  parameter int RST_CYCLES = RST_PULSE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  input wire logic miim_sel_i,
  input wire logic [2:0] miim_port_i,
  input wire logic [PORTS*3-1:0] op_mode_i,
  input wire logic [PORTS-1:0] partner_10hd_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic [7:0] miim_data_o,
  output logic [PORTS-1:0] phy_loopback_o,
  output logic [PORTS-1:0] phy_isolate_o,
  output logic [PORTS-1:0] phy_soft_rst_o,
  output logic [PORTS-1:0] phy_force_link_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Address decode shared by writes and reads.
  function automatic int port_of(input logic [7:0] a);
    case (a)
      OFS_PORT1, OFS_PORT1 - OFS_STATUS_DELTA: return 0;
      OFS_PORT2, OFS_PORT2 - OFS_STATUS_DELTA: return 1;
      OFS_PORT3, OFS_PORT3 - OFS_STATUS_DELTA: return 2;
      OFS_PORT4, OFS_PORT4 - OFS_STATUS_DELTA: return 3;
      OFS_PORT5, OFS_PORT5 - OFS_STATUS_DELTA: return 4;
      default: return -1;
    endcase
  endfunction

  function automatic logic is_ctl(input logic [7:0] a);
    return a[3:0] == OFS_PORT1[3:0];
  endfunction

  function automatic logic port_in_range(input int p);
    return (p >= 0) && (p < PORTS);
  endfunction

  // Only the partner half-duplex ability lives here; status bits 7-1 read zero.
  function automatic logic [7:0] status_word(input logic ability);
    logic [7:0] w;
    w = REG_RESET;
    w[BIT_P10HD] = ability;
    return w;
  endfunction

  logic [7:0] ctl_w [PORTS];
  logic [7:0] status_w [PORTS];
  logic [PORTS-1:0] p10hd_w;
  logic [PORTS-1:0] rst_w;
  logic [PORTS-1:0] wr_sel_w;
  logic [2:0] mode_in_w [PORTS];
  int rd_port_w;
  logic rd_hit_w;
  logic miim_hit_w;
  logic [7:0] rd_word_d;
  logic [7:0] miim_word_d;

  ////////////////////////////////////////////////////////////////////////////
  // Write strobes, one per port; a status offset never takes data.
  always_comb begin
    wr_sel_w = '0;
    for (int p = 0; p < PORTS; p++) begin
      if (wr_i && is_ctl(addr_i) && (port_of(addr_i) == p)) begin
        wr_sel_w[p] = 1'b1;
      end
    end
  end

  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      mode_in_w[p] = op_mode_i[p*3 +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-port instances.
  for (genvar p = 0; p < PORTS; p++) begin : g_port
    ppcs_port_ctl #(
      .RST_CYCLES(RST_CYCLES)
    ) u_port (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(wr_sel_w[p]),
      .wdata_i(wdata_i),
      .op_mode_i(mode_in_w[p]),
      .partner_10hd_i(partner_10hd_i[p]),
      .ctl_q_o(ctl_w[p]),
      .p10hd_o(p10hd_w[p]),
      .phy_soft_rst_o(rst_w[p])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered PHY control outputs, one process per control line.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phy_loopback_o <= '0;
    end else begin
      for (int i = 0; i < PORTS; i++) begin
        phy_loopback_o[i] <= ctl_w[i][BIT_LOOPBACK];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phy_isolate_o <= '0;
    end else begin
      for (int i = 0; i < PORTS; i++) begin
        phy_isolate_o[i] <= ctl_w[i][BIT_ISOLATE];
      end
    end
  end

  // Soft reset reaches the pins one cycle after the register bit shows it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phy_soft_rst_o <= '0;
    end else begin
      for (int i = 0; i < PORTS; i++) begin
        phy_soft_rst_o[i] <= rst_w[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phy_force_link_o <= '0;
    end else begin
      for (int i = 0; i < PORTS; i++) begin
        phy_force_link_o[i] <= ctl_w[i][BIT_FORCE_LINK];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port; unmapped addresses read zero.
  always_comb begin
    rd_port_w = port_of(addr_i);
    rd_hit_w = port_in_range(rd_port_w);
  end

  always_comb begin
    for (int p = 0; p < PORTS; p++) begin
      status_w[p] = status_word(p10hd_w[p]);
    end
  end

  // The word is formed ahead of the flop so the output stays a plain register copy.
  always_comb begin
    rd_word_d = REG_RESET;
    if (rd_hit_w) begin
      if (is_ctl(addr_i)) begin
        rd_word_d = ctl_w[rd_port_w];
      end else begin
        rd_word_d = status_w[rd_port_w];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= rd_i;
    end
  end

  // Read data drops back to zero between reads, so a stale word never looks fresh.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= REG_RESET;
    end else if (rd_i) begin
      rdata_o <= rd_word_d;
    end else begin
      rdata_o <= REG_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The management view reads the same control storage, but shows zero while miim_sel_i is low.
  always_comb begin
    miim_hit_w = port_in_range(int'(miim_port_i));
  end

  always_comb begin
    miim_word_d = REG_RESET;
    if (miim_sel_i && miim_hit_w) begin
      miim_word_d = ctl_w[miim_port_i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      miim_data_o <= REG_RESET;
    end else begin
      miim_data_o <= miim_word_d;
    end
  end
endmodule

/* File: verif/ppcs_top_chk.sv */
// Assertions on the ports of the port PHY control register bank.
`timescale 1ns/1ps
module ppcs_top_chk
  import ppcs_pkg::*;
#(
  parameter int PORTS = NUM_PORTS,
  parameter int RST_CYCLES = RST_PULSE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic [PORTS-1:0] phy_loopback_o,
  input wire logic [PORTS-1:0] phy_isolate_o,
  input wire logic [PORTS-1:0] phy_soft_rst_o,
  input wire logic [PORTS-1:0] phy_force_link_o
);
  // Margin of three cycles covers the register and output stages.
  localparam int SR_MAX = RST_CYCLES + 3;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_read_answer: assert property (rd_i |=> rvalid_o)
    else $error("read not answered");
  a_loop_write: assert property (wr_i && addr_i == OFS_PORT1 |->
    ##2 phy_loopback_o[0] == $past(wdata_i[BIT_LOOPBACK], 2)) else $error("loopback wrong");
  a_isolate_write: assert property (wr_i && addr_i == OFS_PORT2 |->
    ##2 phy_isolate_o[1] == $past(wdata_i[BIT_ISOLATE], 2)) else $error("isolate wrong");
  a_force_write: assert property (wr_i && addr_i == OFS_PORT5 |->
    ##2 phy_force_link_o[4] == $past(wdata_i[BIT_FORCE_LINK], 2)) else $error("force wrong");
  a_srst_start: assert property (wr_i && addr_i == OFS_PORT1 && wdata_i[BIT_SOFT_RST]
    |-> ##2 phy_soft_rst_o[0]) else $error("soft reset not started");
  a_srst_clears: assert property ($rose(phy_soft_rst_o[0]) |->
    ##[1:SR_MAX] !phy_soft_rst_o[0]) else $error("soft reset stuck");
  a_rsvd_zero: assert property (rd_i && addr_i[3:0] == 4'hf |=> !rdata_o[BIT_RSVD])
    else $error("reserved bit set");
  a_mode_legal: assert property (rd_i && addr_i == OFS_PORT1 |=>
    rdata_o[2:0] != 3'h0 && rdata_o[2:0] != 3'h4 && rdata_o[2:0] != 3'h7) else $error("bad mode");
  a_status_upper: assert property (rd_i && addr_i[3:0] == 4'he |=>
    rdata_o[7:1] == 7'h00) else $error("status upper bits set");
endmodule
bind ppcs_top ppcs_top_chk #(.PORTS(PORTS), .RST_CYCLES(RST_CYCLES)) u_chk (.*);

/* File: verif/ppcs_host.sv */
// Management host model driving the register bus.
`timescale 1ns/1ps
module ppcs_host (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  output logic [7:0] addr_o = 8'h00,
  output logic wr_o = 1'b0,
  output logic rd_o = 1'b0,
  output logic [7:0] wdata_o = 8'h00
);
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d & 8'hbf;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    // Released data is inverted so a stale value can never look valid.
    wdata_o <= ~wdata_o;
  endtask
  // Raw write keeps every bit, so the reserved bit can be shown to stay zero.
  task automatic write_raw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~wdata_o;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~addr_o;
    #1;
    ok = rvalid_i;
    d = rdata_i;
  endtask
endmodule

/* File: verif/port_phy_control_status_test.sv */
// Self-checking bench for the port PHY control register bank.
`timescale 1ns/1ps
module port_phy_control_status_test;
  import ppcs_pkg::*;
  typedef struct {logic [2:0] port; logic [7:0] wd; logic [2:0] mode; logic [7:0] exp;} ppcs_row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i, wdata_i, rdata_o, miim_data_o, rd_v;
  logic wr_i, rd_i, rvalid_o, ok;
  logic miim_sel_i = 1'b0;
  logic [2:0] miim_port_i = 3'h2;
  logic [14:0] op_mode_i = 15'h1249;
  logic [4:0] partner_10hd_i = 5'h04;
  logic [4:0] loop_o, iso_o, srst_o, flink_o;
  int err_count = 0;
  int num_checks = 0;
  ppcs_row_t rows [5] = '{'{3'h0, 8'hec, 3'h1, 8'ha9}, '{3'h1, 8'h20, 3'h2, 8'h22},
    '{3'h2, 8'h88, 3'h3, 8'h8b}, '{3'h3, 8'h08, 3'h5, 8'h0d}, '{3'h4, 8'h80, 3'h6, 8'h86}};
  ppcs_top #(.RST_CYCLES(2)) u_ppcs_top (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .miim_sel_i(miim_sel_i),
    .miim_port_i(miim_port_i), .op_mode_i(op_mode_i), .partner_10hd_i(partner_10hd_i),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .miim_data_o(miim_data_o),
    .phy_loopback_o(loop_o), .phy_isolate_o(iso_o), .phy_soft_rst_o(srst_o),
    .phy_force_link_o(flink_o));
  ppcs_host u_ppcs_host (.clk_i(clk_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o),
    .addr_o(addr_i), .wr_o(wr_i), .rd_o(rd_i), .wdata_o(wdata_i));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    u_ppcs_host.read_reg(a, rd_v, ok);
    check("rvalid", 8'(ok), 8'h01);
    check("rdata", rd_v, exp);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_PORT1, 8'h01);
    foreach (rows[i]) begin
      @(posedge clk_i);
      op_mode_i[rows[i].port*3 +: 3] <= rows[i].mode;
      u_ppcs_host.write_reg({1'b0, rows[i].port + 3'h1, 4'hf}, rows[i].wd);
      rd({1'b0, rows[i].port + 3'h1, 4'hf}, rows[i].exp);
      check("loop", 8'(loop_o[rows[i].port]), 8'(rows[i].exp[7]));
      check("iso", 8'(iso_o[rows[i].port]), 8'(rows[i].exp[5]));
      check("flink", 8'(flink_o[rows[i].port]), 8'(rows[i].exp[3]));
      $display("row %0d done", i);
    end
    rd(8'h3e, 8'h01);
    rd(8'h2e, 8'h00);
    check("miim_idle", miim_data_o, 8'h00);
    @(posedge clk_i);
    miim_sel_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    check("miim", miim_data_o, 8'h8b);
    $display("status and miim test done");
    u_ppcs_host.write_reg(OFS_PORT1, 8'h10);
    @(posedge clk_i);
    #1;
    check("srst", 8'(srst_o[0]), 8'h01);
    for (int n = 0; n < 20 && srst_o[0] !== 1'b0; n++) @(posedge clk_i);
    check("srst_end", 8'(srst_o[0]), 8'h00);
    rd(OFS_PORT1, 8'h01);
    // Bit 6 is set on purpose here to show the device keeps it at zero.
    u_ppcs_host.write_raw(OFS_PORT1, 8'h40);
    repeat (2) @(posedge clk_i);
    #1;
    check("srst0", 8'(srst_o[0]), 8'h00);
    rd(OFS_PORT1, 8'h01);
    @(posedge clk_i);
    op_mode_i[5:3] <= 3'h7;
    u_ppcs_host.write_reg(8'h20, 8'hff);
    rd(8'h20, 8'h00);
    rd(OFS_PORT2, 8'h22);
    $display("soft reset and refusal test done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    op_mode_i <= 15'h1249;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    check("outs", 8'(|{loop_o, iso_o, srst_o, flink_o}), 8'h00);
    check("miim_rst", miim_data_o, 8'h00);
    rd(OFS_PORT5, 8'h01);
    $display("mid-run reset test done");
    results();
  end
endmodule
